/* hw/scs_pkg.sv */
// scs_pkg: constants and types for the conversion sequencer
// assumes a single 100 MHz clock domain
package scs_pkg;
    localparam int          CLK_MHZ          = 100;
    localparam int          NBITS            = 16;
    localparam logic [15:0] CODE_ZERO        = 16'h0000;
    localparam logic [15:0] CODE_MID         = 16'h8000;
    localparam logic [15:0] CODE_FULL        = 16'hFFFF;
    // conversion rates in ksps
    localparam int          TURBO_RATE_KSPS  = 2500;
    localparam int          NORMAL_RATE_KSPS = 2000;
    // least cycle period for each rate, rounded up
    localparam int          TURBO_PERIOD_CYC  = (CLK_MHZ * 1000 + TURBO_RATE_KSPS - 1) / TURBO_RATE_KSPS;
    localparam int          NORMAL_PERIOD_CYC = (CLK_MHZ * 1000 + NORMAL_RATE_KSPS - 1) / NORMAL_RATE_KSPS;
    // internal conversion oscillator: one bit trial per tick
    localparam int          OSC_DIV          = 2;
    localparam logic [4:0]  BIT_LAST         = 5'h0F;

    typedef enum logic [2:0] {
        SCS_ACQ,
        SCS_OPEN_GND,
        SCS_HOLD,
        SCS_TRIAL,
        SCS_DONE
    } scs_state_t;
endpackage

/* hw/scs_osc_if.sv */
// scs_osc_if: tick carrier between oscillator and sequencer
// assumes one clock
`timescale 1ns/1ps
interface scs_osc_if;
    logic run;
    logic tick;
    modport osc (input run, output tick);
    modport seq (output run, input tick);
endinterface

/* hw/scs_conv_osc.sv */
// scs_conv_osc: internal conversion oscillator, a tick enable divider
// assumes run is driven from the same clock
`timescale 1ns/1ps
module scs_conv_osc (
    input  wire logic clock,
    input  wire logic arst_n,
    scs_osc_if.osc    osc
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;

    always_comb begin
        nxt_cnt = 4'h0;
        if (osc.run && cnt_ff != 4'((scs_pkg::OSC_DIV) - 1)) begin
            nxt_cnt = cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // free of any serial clock; restarts phase on each conversion
    assign osc.tick = osc.run && (cnt_ff == 4'((scs_pkg::OSC_DIV) - 1));
endmodule // scs_conv_osc

/* hw/scs_sequencer.sv */
// scs_sequencer: successive-approximation conversion sequencer
// assumes convert_strobe and fast_mode come from pins; comparator from analog
`timescale 1ns/1ps
module scs_sequencer (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        convert_strobe,
    input  wire logic        fast_mode,
    input  wire logic        comparator_out,
    input  wire logic        over_range,
    input  wire logic        under_range,
    output logic             comparator_ground_switch_pos,
    output logic             comparator_ground_switch_neg,
    output logic             array_to_input,
    output logic [15:0]      array_to_reference,
    output logic             powered,
    output logic             busy,
    output logic             result_valid,
    output logic             first_result_invalid,
    output logic [15:0]      result
);
    // three-stage pin synchronisers
    logic [2:0]  strobe_sync_ff;
    logic [2:0]  fast_sync_ff;
    logic        strobe_level_ff;
    logic        nxt_strobe_level;
    logic        fast_level_ff;
    logic        nxt_fast_level;

    scs_pkg::scs_state_t state_ff;
    scs_pkg::scs_state_t nxt_state;
    logic [4:0]  bit_ff;
    logic [4:0]  nxt_bit;
    logic [15:0] trial_ff;
    logic [15:0] nxt_trial;
    logic [15:0] result_ff;
    logic [15:0] nxt_result;
    logic        done_ff;
    logic        nxt_done;
    logic        turbo_ff;
    logic        nxt_turbo;
    logic        turbo_fresh_ff;
    logic        nxt_turbo_fresh;
    logic        first_bad_ff;
    logic        nxt_first_bad;
    logic [7:0]  gap_ff;
    logic [7:0]  nxt_gap;
    logic        strobe_rise;

    scs_osc_if osc_bus ();

    scs_conv_osc u_osc (
        .clock  (clock),
        .arst_n (arst_n),
        .osc    (osc_bus.osc)
    );

    function automatic logic [15:0] bit_mask(input logic [4:0] idx);
        bit_mask = 16'h8000 >> (4'hF - idx[3:0]);
    endfunction

    // a change counts only once the last two stages agree, so a settling middle stage never starts a conversion
    always_comb begin
        nxt_strobe_level = (strobe_sync_ff[1] == strobe_sync_ff[2]) ? strobe_sync_ff[2] : strobe_level_ff;
        nxt_fast_level   = (fast_sync_ff[1] == fast_sync_ff[2]) ? fast_sync_ff[2] : fast_level_ff;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strobe_sync_ff  <= 3'h0;
            fast_sync_ff    <= 3'h0;
            strobe_level_ff <= 1'b0;
            fast_level_ff   <= 1'b0;
        end else begin
            strobe_sync_ff  <= {strobe_sync_ff[1:0], convert_strobe};
            fast_sync_ff    <= {fast_sync_ff[1:0], fast_mode};
            strobe_level_ff <= nxt_strobe_level;
            fast_level_ff   <= nxt_fast_level;
        end
    end

    assign strobe_rise = nxt_strobe_level && !strobe_level_ff;

    // next-state logic
    always_comb begin
        nxt_state       = state_ff;
        nxt_bit         = bit_ff;
        nxt_trial       = trial_ff;
        nxt_result      = result_ff;
        nxt_done        = 1'b0;
        nxt_turbo       = turbo_ff;
        nxt_turbo_fresh = turbo_fresh_ff;
        nxt_first_bad   = first_bad_ff;
        nxt_gap         = (gap_ff != 8'h00) ? gap_ff - 8'h01 : 8'h00;
        case (state_ff)
            scs_pkg::SCS_ACQ: begin
                // throughput cap: strobes inside the least period are ignored
                if (strobe_rise && gap_ff == 8'h00) begin
                    nxt_turbo = fast_level_ff;
                    // first result after entering turbo is flagged for the host
                    nxt_first_bad = fast_level_ff && !turbo_fresh_ff;
                    nxt_turbo_fresh = fast_level_ff;
                    nxt_gap = fast_level_ff ? 8'(scs_pkg::TURBO_PERIOD_CYC - 1)
                                            : 8'(scs_pkg::NORMAL_PERIOD_CYC - 1);
                    nxt_state = scs_pkg::SCS_OPEN_GND;
                end
            end
            scs_pkg::SCS_OPEN_GND: begin
                nxt_state = scs_pkg::SCS_HOLD;
            end
            scs_pkg::SCS_HOLD: begin
                nxt_bit   = scs_pkg::BIT_LAST;
                nxt_trial = scs_pkg::CODE_MID;
                nxt_state = scs_pkg::SCS_TRIAL;
            end
            scs_pkg::SCS_TRIAL: begin
                if (osc_bus.tick) begin
                    // comparator high means the trial overshoots: drop the bit
                    if (comparator_out) begin
                        nxt_trial = trial_ff & ~bit_mask(bit_ff);
                    end
                    if (bit_ff == 5'h00) begin
                        nxt_state = scs_pkg::SCS_DONE;
                    end else begin
                        nxt_bit   = bit_ff - 5'h01;
                        nxt_trial = (comparator_out ? trial_ff & ~bit_mask(bit_ff) : trial_ff)
                                    | bit_mask(bit_ff - 5'h01);
                    end
                end
            end
            scs_pkg::SCS_DONE: begin
                if (over_range) begin
                    nxt_result = scs_pkg::CODE_FULL;
                end else if (under_range) begin
                    nxt_result = scs_pkg::CODE_ZERO;
                end else begin
                    nxt_result = trial_ff;
                end
                nxt_done  = 1'b1;
                nxt_state = scs_pkg::SCS_ACQ;
            end
            default: begin
                nxt_state = scs_pkg::SCS_ACQ;
            end
        endcase
        if (!fast_level_ff && state_ff == scs_pkg::SCS_ACQ && !strobe_rise) begin
            nxt_turbo_fresh = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff       <= scs_pkg::SCS_ACQ;
            bit_ff         <= 5'h00;
            trial_ff       <= 16'h0000;
            result_ff      <= 16'h0000;
            done_ff        <= 1'b0;
            turbo_ff       <= 1'b0;
            turbo_fresh_ff <= 1'b0;
            first_bad_ff   <= 1'b0;
            gap_ff         <= 8'h00;
        end else begin
            state_ff       <= nxt_state;
            bit_ff         <= nxt_bit;
            trial_ff       <= nxt_trial;
            result_ff      <= nxt_result;
            done_ff        <= nxt_done;
            turbo_ff       <= nxt_turbo;
            turbo_fresh_ff <= nxt_turbo_fresh;
            first_bad_ff   <= nxt_first_bad;
            gap_ff         <= nxt_gap;
        end
    end

    assign osc_bus.run = (state_ff == scs_pkg::SCS_TRIAL);

    always_comb begin
        comparator_ground_switch_pos = (state_ff == scs_pkg::SCS_ACQ) || (state_ff == scs_pkg::SCS_DONE);
        comparator_ground_switch_neg = comparator_ground_switch_pos;
        // arrays leave the inputs one cycle after the ground switches open
        array_to_input = comparator_ground_switch_pos || (state_ff == scs_pkg::SCS_OPEN_GND);
        array_to_reference = (state_ff == scs_pkg::SCS_TRIAL) ? trial_ff : 16'h0000;
        // normal mode sleeps in acquisition; turbo stays up
        powered = fast_level_ff || turbo_ff || (state_ff != scs_pkg::SCS_ACQ);
    end

    assign busy                 = (state_ff != scs_pkg::SCS_ACQ);
    assign result_valid         = done_ff;
    assign first_result_invalid = first_bad_ff;
    assign result               = result_ff;

    property p_ground_first;
        @(posedge clock) disable iff (!arst_n)
        (state_ff == scs_pkg::SCS_ACQ && nxt_state == scs_pkg::SCS_OPEN_GND)
            |=> !comparator_ground_switch_pos && array_to_input ##1 !array_to_input;
    endproperty
    a_ground_first: assert property (p_ground_first) else $error("ground switch order wrong");

    property p_acq_switches;
        @(posedge clock) disable iff (!arst_n)
        (state_ff == scs_pkg::SCS_ACQ) |-> comparator_ground_switch_pos && comparator_ground_switch_neg && array_to_input;
    endproperty
    a_acq_switches: assert property (p_acq_switches) else $error("acquisition switches wrong");

    sequence s_start;
        state_ff == scs_pkg::SCS_HOLD;
    endsequence
    property p_msb_first;
        @(posedge clock) disable iff (!arst_n)
        s_start |=> array_to_reference == 16'h8000 && bit_ff == 5'h0F;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb trial not first");

    property p_conv_length;
        @(posedge clock) disable iff (!arst_n)
        s_start |-> ##[33:34] result_valid;
    endproperty
    a_conv_length: assert property (p_conv_length) else $error("conversion length wrong");

    property p_done_acq;
        @(posedge clock) disable iff (!arst_n)
        result_valid |-> !busy && comparator_ground_switch_pos;
    endproperty
    a_done_acq: assert property (p_done_acq) else $error("done outside acquisition");

    property p_overrange;
        @(posedge clock) disable iff (!arst_n)
        (state_ff == scs_pkg::SCS_DONE && over_range) |=> result == 16'hFFFF;
    endproperty
    a_overrange: assert property (p_overrange) else $error("overrange not clamped");

    property p_underrange;
        @(posedge clock) disable iff (!arst_n)
        (state_ff == scs_pkg::SCS_DONE && !over_range && under_range) |=> result == 16'h0000;
    endproperty
    a_underrange: assert property (p_underrange) else $error("underrange not clamped");

    property p_result_trial;
        @(posedge clock) disable iff (!arst_n)
        (state_ff == scs_pkg::SCS_DONE && !over_range && !under_range) |=> result == $past(trial_ff);
    endproperty
    a_result_trial: assert property (p_result_trial) else $error("result not from trial");

    property p_power;
        @(posedge clock) disable iff (!arst_n)
        (state_ff == scs_pkg::SCS_ACQ && !fast_level_ff && !turbo_ff) |-> !powered;
    endproperty
    a_power: assert property (p_power) else $error("normal mode not powered down");

    property p_turbo_on;
        @(posedge clock) disable iff (!arst_n)
        fast_level_ff |-> powered;
    endproperty
    a_turbo_on: assert property (p_turbo_on) else $error("turbo powered down");

    property p_mode_hold;
        @(posedge clock) disable iff (!arst_n)
        (busy && $past(busy)) |-> $stable(turbo_ff);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid conversion");

    property p_normal_first_ok;
        @(posedge clock) disable iff (!arst_n)
        (state_ff == scs_pkg::SCS_OPEN_GND && !turbo_ff) |-> !first_result_invalid;
    endproperty
    a_normal_first_ok: assert property (p_normal_first_ok) else $error("normal result flagged");
endmodule // scs_sequencer

/* verification/scs_host_model.sv */
// scs_host_model: host and analog stand-in at the far side of the sequencer
// assumes the sequencer's clock; start is a one-cycle request from the bench
`timescale 1ns/1ps
module scs_host_model (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        start,
    input  wire logic        turbo,
    input  wire logic [15:0] vin,
    input  wire logic        over,
    input  wire logic        under,
    input  wire logic        array_to_input,
    input  wire logic [15:0] array_to_reference,
    input  wire logic        result_valid,
    input  wire logic        first_result_invalid,
    input  wire logic [15:0] result,
    output logic             convert_strobe,
    output logic             fast_mode,
    output logic             comparator_out,
    output logic             over_range,
    output logic             under_range,
    output logic [7:0]       n_kept_ff,
    output logic [15:0]      kept_ff
);
    logic [1:0]  hi_ff;
    logic [15:0] held_ff;
    logic [1:0]  rng_ff;
    assign fast_mode      = turbo;
    // strobe high three cycles so the pin synchroniser always sees it
    assign convert_strobe = (hi_ff != 2'h0);
    // sample freezes once the arrays leave the inputs, so late input moves are invisible
    assign comparator_out = (array_to_reference > held_ff);
    assign over_range     = rng_ff[1];
    assign under_range    = rng_ff[0];
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hi_ff     <= 2'h0;
            held_ff   <= 16'h0000;
            rng_ff    <= 2'h0;
            n_kept_ff <= 8'h00;
            kept_ff   <= 16'h0000;
        end else begin
            hi_ff <= start ? 2'h3 : ((hi_ff != 2'h0) ? hi_ff - 2'h1 : 2'h0);
            if (array_to_input) begin
                held_ff <= vin;
                rng_ff  <= {over, under};
            end
            if (result_valid && !first_result_invalid) begin
                n_kept_ff <= n_kept_ff + 8'h01;
                kept_ff   <= result;
            end
        end
    end
endmodule // scs_host_model

/* verification/tb.sv */
// tb: self-checking bench for the conversion sequencer
// assumes the host model closes the comparator loop around the design
`timescale 1ns/1ps
module tb;
    logic        clock, arst_n, start, turbo, over, under;
    logic [15:0] vin, array_to_reference, result, kept_ff;
    logic        convert_strobe, fast_mode, comparator_out, over_range, under_range;
    logic        comparator_ground_switch_pos, comparator_ground_switch_neg, array_to_input;
    logic        powered, busy, result_valid, first_result_invalid;
    logic [7:0]  n_kept_ff;
    int          miscompares, n_compared, n_valid, cycles;
    logic [15:0] codes [6] = '{16'h0000, 16'h0001, 16'h7FFF, 16'h8000, 16'h8001, 16'hA5C3};

    scs_sequencer i_scs_sequencer (.clock(clock), .arst_n(arst_n), .convert_strobe(convert_strobe),
        .fast_mode(fast_mode), .comparator_out(comparator_out), .over_range(over_range),
        .under_range(under_range), .comparator_ground_switch_pos(comparator_ground_switch_pos),
        .comparator_ground_switch_neg(comparator_ground_switch_neg), .array_to_input(array_to_input),
        .array_to_reference(array_to_reference), .powered(powered), .busy(busy),
        .result_valid(result_valid), .first_result_invalid(first_result_invalid), .result(result));

    scs_host_model i_scs_host_model (.clock(clock), .arst_n(arst_n), .start(start), .turbo(turbo),
        .vin(vin), .over(over), .under(under), .array_to_input(array_to_input),
        .array_to_reference(array_to_reference), .result_valid(result_valid),
        .first_result_invalid(first_result_invalid), .result(result), .convert_strobe(convert_strobe),
        .fast_mode(fast_mode), .comparator_out(comparator_out), .over_range(over_range),
        .under_range(under_range), .n_kept_ff(n_kept_ff), .kept_ff(kept_ff));

    always #5 clock = ~clock;

    always @(posedge clock) begin
        if (result_valid === 1'h1) begin
            n_valid <= n_valid + 1;
        end
        cycles <= cycles + 1;
        // run needs about 1500 cycles
        if (cycles == 6000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic convert(input logic [15:0] v, input logic o, input logic u, input logic m,
                           input logic [15:0] exp, input logic exp_bad);
        int          w;
        logic [7:0]  kept0;
        logic [15:0] kept_v0;
        @(posedge clock) begin
            vin   <= v;
            over  <= o;
            under <= u;
            turbo <= m;
        end
        tick(6);
        kept0 = n_kept_ff;
        kept_v0 = kept_ff;
        w = 0;
        @(posedge clock) start <= 1'h1;
        @(posedge clock) start <= 1'h0;
        do begin
            tick(1);
            w++;
        end while (busy !== 1'h1 && w < 20);
        check(busy, 1'h1);
        check({comparator_ground_switch_pos, comparator_ground_switch_neg, array_to_input}, 3'h1);
        check(powered, 1'h1);
        tick(1);
        check(array_to_input, 1'h0);
        tick(1);
        check(array_to_reference, 16'h8000);
        // a moving input after the sample must not reach this result
        @(posedge clock) vin <= ~v;
        while (result_valid !== 1'h1 && w < 80) begin
            tick(1);
            w++;
        end
        check(result_valid, 1'h1);
        check(result, exp);
        check({busy, array_to_input, comparator_ground_switch_pos, comparator_ground_switch_neg}, 4'h7);
        check(array_to_reference, 16'h0000);
        check(powered, m);
        check(first_result_invalid, exp_bad);
        tick(2);
        check(n_kept_ff, 8'(kept0 + {7'h00, ~exp_bad}));
        check(kept_ff, exp_bad ? kept_v0 : exp);
        tick(14);
    endtask

    task automatic pair(input logic m, input int gap, input int exp_n);
        int n0;
        @(posedge clock) turbo <= m;
        tick(6);
        n0 = n_valid;
        @(posedge clock) start <= 1'h1;
        @(posedge clock) start <= 1'h0;
        repeat (gap - 1) @(posedge clock);
        start <= 1'h1;
        @(posedge clock) start <= 1'h0;
        tick(120);
        check(32'(n_valid - n0), 32'(exp_n));
    endtask

    task automatic print_verdict();
        $display("compared=%0d miscompares=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'h0;
        arst_n = 1'h0;
        start = 1'h0;
        turbo = 1'h0;
        vin = 16'h0000;
        over = 1'h0;
        under = 1'h0;
        miscompares = 0;
        n_compared = 0;
        n_valid = 0;
        cycles = 0;
        tick(3);
        check({comparator_ground_switch_pos, comparator_ground_switch_neg, array_to_input, busy}, 4'hE);
        check({result_valid, powered, result}, 18'h00000);
        @(posedge clock) arst_n <= 1'h1;
        tick(4);
        foreach (codes[i]) begin
            convert(codes[i], 1'h0, 1'h0, 1'h0, codes[i], 1'h0);
        end
        convert(16'h1234, 1'h1, 1'h0, 1'h0, 16'hFFFF, 1'h0);
        convert(16'hFEDC, 1'h0, 1'h1, 1'h0, 16'h0000, 1'h0);
        convert(16'h4321, 1'h0, 1'h0, 1'h1, 16'h4321, 1'h1);
        convert(16'h0F0F, 1'h0, 1'h0, 1'h1, 16'h0F0F, 1'h0);
        pair(1'h1, 40, 2);
        pair(1'h1, 39, 1);
        pair(1'h1, 15, 1);
        pair(1'h0, 50, 2);
        pair(1'h0, 44, 1);
        print_verdict();
    end
endmodule // tb
